// ### mb_out_pkg.sv
// constants and types for the modbus output request handler
// ==========================================================
// Operation
// - a read exception status request is answered with code 07 and one byte of output state.
// - bit 0 of that byte is digital output 0 and bit 7 is digital output 7, set meaning on.
// - write multiple coils accepts starting addresses 0 to 15, one per digital output.
// - write multiple coils accepts a quantity of 1 to 16 outputs.
// - write multiple coils is answered with its code, echoed address and echoed quantity.
// - the first coil data byte covers the eight outputs from the start address lsb first, the second the next eight.
// - with format 0 register data is float volts and addresses 1 to 14 are accepted.
// - with format 1 register data is 16-bit counts and addresses 0 to 7 are accepted.
// - write multiple registers is answered with code 16, echoed address and quantity.
// - float mode uses two registers per analog output, counts mode one register each.
// - a failed request gets the code with its top bit set and exception code 01 or 02.
// - a float value is split high word first over two registers.
package mb_out_pkg;
  localparam logic [7:0]  FC_READ_EXC   = 8'h07;
  localparam logic [7:0]  FC_WRITE_COIL = 8'h0F;
  localparam logic [7:0]  FC_WRITE_REG  = 8'h10;
  localparam logic [7:0]  EXC_FLAG      = 8'h80;
  localparam logic [7:0]  EXC_BAD_FUNC  = 8'h01;
  localparam logic [7:0]  EXC_BAD_ADDR  = 8'h02;
  localparam logic [15:0] COIL_ADDR_MAX = 16'h000F;
  localparam logic [15:0] COIL_QTY_MAX  = 16'h0010;
  localparam logic [15:0] FLT_ADDR_MIN  = 16'h0001;
  localparam logic [15:0] FLT_ADDR_MAX  = 16'h000E;
  localparam logic [15:0] CNT_ADDR_MAX  = 16'h0007;
  localparam logic [15:0] REG_QTY_MAX   = 16'h007B;
  localparam logic [15:0] DOUT_RESET    = 16'h0000;
  localparam logic [15:0] AOUT_RESET    = 16'h0000;
  localparam int          NUM_DOUT      = 16;
  localparam int          NUM_AOUT      = 8;
  localparam int          REG_SLOTS     = 16;
  typedef enum logic {FMT_FLOAT, FMT_COUNTS} fmt_e;
  typedef enum logic [2:0] {
    ST_FUNC, ST_ADDR_HI, ST_ADDR_LO, ST_QTY_HI, ST_QTY_LO, ST_COUNT, ST_DATA, ST_RESP
  } rx_state_e;
endpackage

// ### modbus_output_slave_handler.sv
// modbus output request handler: fc 07, 15 and 16
`timescale 1ns/1ps
module modbus_output_slave_handler (
  input  wire logic        clock_i,
  input  wire logic        reset_n_i,
  input  wire logic        register_format_select_i,
  input  wire logic        rx_valid_i,
  input  wire logic [7:0]  rx_data_i,
  input  wire logic        rx_last_i,
  output logic             rx_ready_o,
  output logic             tx_valid_o,
  output logic [7:0]       tx_data_o,
  output logic             tx_last_o,
  input  wire logic        tx_ready_i,
  output logic [15:0]      digital_out_o,
  output logic [255:0]     analog_reg_o,
  output logic [7:0]       last_response_function_query_o,
  output logic [7:0]       last_exception_code_query_o
);
  // ==========================================================
  // state
  mb_out_pkg::rx_state_e state, next_state;
  logic [7:0]  func, next_func;
  logic [15:0] addr, next_addr;
  logic [15:0] qty, next_qty;
  logic [7:0]  idx, next_idx;
  logic [15:0] dout, next_dout;
  logic [15:0] coil_buf, next_coil_buf;
  logic [15:0] regs [mb_out_pkg::REG_SLOTS];
  logic [15:0] next_regs [mb_out_pkg::REG_SLOTS];
  logic [15:0] reg_buf [mb_out_pkg::REG_SLOTS];
  logic [15:0] next_reg_buf [mb_out_pkg::REG_SLOTS];
  logic [7:0]  resp [6];
  logic [7:0]  next_resp [6];
  logic [2:0]  resp_len, next_resp_len;
  logic [2:0]  tx_idx, next_tx_idx;
  logic [7:0]  last_fc, next_last_fc;
  logic [7:0]  last_exc, next_last_exc;

  // ==========================================================
  // range checks
  function automatic logic range_ok(input logic [7:0] f, input logic [15:0] a,
                                    input logic [15:0] q, input logic fmt);
    logic [16:0] lastq;
    lastq = {1'b0, a} + {1'b0, q} - 17'd1;
    range_ok = 1'b0;
    if (f == mb_out_pkg::FC_WRITE_COIL) begin
      range_ok = (a <= mb_out_pkg::COIL_ADDR_MAX) && (q != 16'h0000)
                 && (q <= mb_out_pkg::COIL_QTY_MAX)
                 && (lastq <= {1'b0, mb_out_pkg::COIL_ADDR_MAX});
    end else if (fmt == mb_out_pkg::FMT_COUNTS) begin
      range_ok = (q != 16'h0000) && (q <= mb_out_pkg::REG_QTY_MAX)
                 && (lastq <= {1'b0, mb_out_pkg::CNT_ADDR_MAX});
    end else begin
      range_ok = (a >= mb_out_pkg::FLT_ADDR_MIN) && (q != 16'h0000)
                 && (q <= mb_out_pkg::REG_QTY_MAX)
                 && (lastq <= {1'b0, mb_out_pkg::FLT_ADDR_MAX});
    end
  endfunction

  function automatic logic known_fc(input logic [7:0] f);
    known_fc = (f == mb_out_pkg::FC_READ_EXC) || (f == mb_out_pkg::FC_WRITE_COIL)
               || (f == mb_out_pkg::FC_WRITE_REG);
  endfunction

  // ==========================================================
  // request parse and response build
  always_comb begin
    next_state    = state;
    next_func     = func;
    next_addr     = addr;
    next_qty      = qty;
    next_idx      = idx;
    next_dout     = dout;
    next_coil_buf = coil_buf;
    next_regs     = regs;
    next_reg_buf  = reg_buf;
    next_resp     = resp;
    next_resp_len = resp_len;
    next_tx_idx   = tx_idx;
    next_last_fc  = last_fc;
    next_last_exc = last_exc;
    rx_ready_o    = (state != mb_out_pkg::ST_RESP);
    unique case (state)
      mb_out_pkg::ST_FUNC: begin
        if (rx_valid_i) begin
          next_func = rx_data_i;
          next_coil_buf = 16'h0000;
          next_idx = 8'h00;
          next_tx_idx = 3'd0;
          next_resp[0] = rx_data_i;
          if (rx_data_i == mb_out_pkg::FC_READ_EXC) begin
            // lone code, answer with outputs 7..0
            next_resp[1] = dout[7:0];
            next_resp_len = 3'd2;
            next_last_fc = rx_data_i;
            next_state = mb_out_pkg::ST_RESP;
          end else if (!known_fc(rx_data_i)) begin
            next_resp[0] = rx_data_i | mb_out_pkg::EXC_FLAG;
            next_resp[1] = mb_out_pkg::EXC_BAD_FUNC;
            next_resp_len = 3'd2;
            next_last_fc = next_resp[0];
            next_last_exc = mb_out_pkg::EXC_BAD_FUNC;
            next_state = rx_last_i ? mb_out_pkg::ST_RESP : mb_out_pkg::ST_DATA;
          end else begin
            next_state = mb_out_pkg::ST_ADDR_HI;
          end
        end
      end
      mb_out_pkg::ST_ADDR_HI: if (rx_valid_i) begin
        next_addr[15:8] = rx_data_i;
        next_state = mb_out_pkg::ST_ADDR_LO;
      end
      mb_out_pkg::ST_ADDR_LO: if (rx_valid_i) begin
        next_addr[7:0] = rx_data_i;
        next_state = mb_out_pkg::ST_QTY_HI;
      end
      mb_out_pkg::ST_QTY_HI: if (rx_valid_i) begin
        next_qty[15:8] = rx_data_i;
        next_state = mb_out_pkg::ST_QTY_LO;
      end
      mb_out_pkg::ST_QTY_LO: if (rx_valid_i) begin
        next_qty[7:0] = rx_data_i;
        next_state = mb_out_pkg::ST_COUNT;
      end
      mb_out_pkg::ST_COUNT: if (rx_valid_i) begin
        next_state = (rx_last_i || rx_data_i == 8'h00) ? mb_out_pkg::ST_RESP
                                                       : mb_out_pkg::ST_DATA;
      end
      mb_out_pkg::ST_DATA: if (rx_valid_i) begin
        next_idx = idx + 8'd1;
        if (func == mb_out_pkg::FC_WRITE_COIL) begin
          // byte 0 is outputs addr+7..addr, byte 1 outputs addr+15..addr+8
          if (idx == 8'd0) next_coil_buf[7:0] = rx_data_i;
          if (idx == 8'd1) next_coil_buf[15:8] = rx_data_i;
        end else if (idx < 8'(2 * mb_out_pkg::REG_SLOTS)) begin
          if (!idx[0]) next_reg_buf[idx[4:1]][15:8] = rx_data_i;
          else         next_reg_buf[idx[4:1]][7:0]  = rx_data_i;
        end
        if (rx_last_i) next_state = mb_out_pkg::ST_RESP;
      end
      mb_out_pkg::ST_RESP: begin
        if (tx_idx == 3'd0 && resp_len == 3'd0) begin
          next_resp_len = 3'd5;
          next_resp[1] = addr[15:8];
          next_resp[2] = addr[7:0];
          next_resp[3] = qty[15:8];
          next_resp[4] = qty[7:0];
          if (!range_ok(func, addr, qty, register_format_select_i)) begin
            next_resp[0] = func | mb_out_pkg::EXC_FLAG;
            next_resp[1] = mb_out_pkg::EXC_BAD_ADDR;
            next_resp_len = 3'd2;
            next_last_exc = mb_out_pkg::EXC_BAD_ADDR;
          end else if (func == mb_out_pkg::FC_WRITE_COIL) begin
            for (int i = 0; i < mb_out_pkg::NUM_DOUT; i++) begin
              if (i >= int'(addr) && i < int'(addr) + int'(qty))
                next_dout[i] = coil_buf[i - int'(addr)];
            end
          end else begin
            for (int i = 0; i < mb_out_pkg::REG_SLOTS; i++) begin
              if (i >= int'(addr) && i < int'(addr) + int'(qty))
                next_regs[i] = reg_buf[i - int'(addr)];
            end
          end
          next_last_fc = next_resp[0];
        end else if (tx_ready_i) begin
          next_tx_idx = tx_idx + 3'd1;
          if (tx_idx + 3'd1 == resp_len) begin
            next_resp_len = 3'd0;
            next_tx_idx = 3'd0;
            next_state = mb_out_pkg::ST_FUNC;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state    <= mb_out_pkg::ST_FUNC;
      func     <= 8'h00;
      addr     <= 16'h0000;
      qty      <= 16'h0000;
      idx      <= 8'h00;
      dout     <= mb_out_pkg::DOUT_RESET;
      coil_buf <= 16'h0000;
      for (int i = 0; i < mb_out_pkg::REG_SLOTS; i++) begin
        regs[i]    <= mb_out_pkg::AOUT_RESET;
        reg_buf[i] <= 16'h0000;
      end
      for (int i = 0; i < 6; i++) resp[i] <= 8'h00;
      resp_len <= 3'd0;
      tx_idx   <= 3'd0;
      last_fc  <= 8'h00;
      last_exc <= 8'h00;
    end else begin
      state    <= next_state;
      func     <= next_func;
      addr     <= next_addr;
      qty      <= next_qty;
      idx      <= next_idx;
      dout     <= next_dout;
      coil_buf <= next_coil_buf;
      regs     <= next_regs;
      reg_buf  <= next_reg_buf;
      resp     <= next_resp;
      resp_len <= next_resp_len;
      tx_idx   <= next_tx_idx;
      last_fc  <= next_last_fc;
      last_exc <= next_last_exc;
    end
  end

  // ==========================================================
  // outputs
  assign tx_valid_o = (state == mb_out_pkg::ST_RESP) && (resp_len != 3'd0);
  assign tx_data_o  = tx_valid_o ? resp[tx_idx] : 8'h00;
  assign tx_last_o  = tx_valid_o && (tx_idx + 3'd1 == resp_len);
  assign digital_out_o = dout;
  assign last_response_function_query_o = last_fc;
  assign last_exception_code_query_o    = last_exc;
  for (genvar g = 0; g < mb_out_pkg::REG_SLOTS; g++) begin : g_ao
    assign analog_reg_o[g*16 +: 16] = regs[g];
  end
endmodule

// ### mb_out_chk.sv
// assertion checker for the modbus output request handler
`timescale 1ns/1ps
module mb_out_chk (
  input wire logic        clock_i,
  input wire logic        reset_n_i,
  input wire logic        rx_valid_i,
  input wire logic [7:0]  rx_data_i,
  input wire logic        rx_last_i,
  input wire logic        rx_ready_o,
  input wire logic        tx_valid_o,
  input wire logic [7:0]  tx_data_o,
  input wire logic        tx_last_o,
  input wire logic        tx_ready_i,
  input wire logic [15:0] digital_out_o
);
  logic rx_first;
  logic tx_first;
  logic next_rx_first;
  logic next_tx_first;
  logic [7:0] req_fc;
  logic [7:0] next_req_fc;
  wire  rx_take = rx_valid_i && rx_ready_o;
  wire  tx_take = tx_valid_o && tx_ready_i;
  // first byte trackers
  always_comb begin
    next_rx_first = rx_take ? rx_last_i : rx_first;
    next_tx_first = tx_take ? tx_last_o : tx_first;
    next_req_fc   = (rx_take && rx_first) ? rx_data_i : req_fc;
  end
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_first <= 1'b1;
      tx_first <= 1'b1;
      req_fc   <= 8'h00;
    end else begin
      rx_first <= next_rx_first;
      tx_first <= next_tx_first;
      req_fc   <= next_req_fc;
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_take07;
    rx_take && rx_first && rx_last_i && rx_data_i == 8'h07;
  endsequence
  AST_RD_ECHO: assert property (s_take07 |=> tx_valid_o && tx_data_o == 8'h07)
    else $error("status echo wrong");
  AST_RD_DATA: assert property (s_take07 ##1 tx_take |=>
    tx_valid_o && tx_last_o && tx_data_o == digital_out_o[7:0]) else $error("status byte wrong");
  AST_RX_HOLD: assert property (tx_valid_o |-> !rx_ready_o)
    else $error("request taken during response");
  AST_OUT_WHEN: assert property ($changed(digital_out_o) |-> tx_valid_o && tx_first)
    else $error("outputs moved outside response start");
  AST_TX_STAND: assert property (tx_valid_o && !tx_ready_i |=>
    tx_valid_o && $stable(tx_data_o) && $stable(tx_last_o)) else $error("tx byte dropped");
  AST_EXC_FORM: assert property (tx_take && tx_first && tx_data_o[7] |=>
    tx_valid_o && tx_last_o && tx_data_o inside {8'h01, 8'h02}) else $error("bad exception");
  AST_EXC_KEEP: assert property (tx_valid_o && tx_first && tx_data_o[7] |->
    $stable(digital_out_o)) else $error("outputs changed on exception");
  AST_WR_LAT: assert property (rx_take && rx_last_i && !rx_first
    && (req_fc == 8'h0F || req_fc == 8'h10) |=>
    !tx_valid_o ##1 tx_valid_o) else $error("write answer latency wrong");
endmodule
bind modbus_output_slave_handler mb_out_chk i_chk (.clock_i, .reset_n_i, .rx_valid_i,
  .rx_data_i, .rx_last_i, .rx_ready_o, .tx_valid_o, .tx_data_o, .tx_last_o, .tx_ready_i,
  .digital_out_o);

// ### mb_master_model.sv
// modbus master model: sends request bytes, collects response bytes
`timescale 1ns/1ps
module mb_master_model (
  input  wire logic       clock_i,
  input  wire logic       rx_ready_i,
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_last_i,
  output logic            rx_valid_o = 1'b0,
  output logic [7:0]      rx_data_o = 8'hA5,
  output logic            rx_last_o = 1'b0,
  output logic            tx_ready_o = 1'b0
);
  logic       slow = 1'b0;
  logic [7:0] resp[$];
  // request sent whole, status read as code alone
  task automatic transact(input logic [7:0] req[$]);
    resp = {};
    foreach (req[i]) begin
      rx_valid_o = 1'b1;
      rx_data_o = req[i];
      rx_last_o = (i == req.size() - 1);
      do @(posedge clock_i); while (!rx_ready_i);
      #1;
    end
    rx_valid_o = 1'b0;
    rx_last_o = 1'b0;
    rx_data_o = ~rx_data_o;
    // whole answer collected, slow mode stalls
    tx_ready_o = ~slow;
    forever begin
      @(posedge clock_i);
      if (tx_valid_i && tx_ready_o) begin
        resp.push_back(tx_data_i);
        if (tx_last_i) break;
      end
      #1 tx_ready_o = slow ? ~tx_ready_o : 1'b1;
    end
    #1 tx_ready_o = 1'b0;
  endtask
endmodule

// ### modbus_output_slave_handler_tb_top.sv
// testbench for the modbus output request handler
`timescale 1ns/1ps
module modbus_output_slave_handler_tb_top;
  logic         clock_i = 1'b0;
  logic         reset_n_i = 1'b0;
  logic         register_format_select_i = 1'b0;
  logic         rx_valid_i, rx_last_i, rx_ready_o, tx_valid_o, tx_last_o, tx_ready_i;
  logic [7:0]   rx_data_i, tx_data_o;
  logic [15:0]  digital_out_o;
  logic [255:0] analog_reg_o;
  logic [7:0]   last_response_function_query_o;
  logic [7:0]   last_exception_code_query_o;
  int           n_errors = 0;
  int           cmp_count = 0;
  always #4 clock_i = ~clock_i;
  modbus_output_slave_handler i_dut (.clock_i, .reset_n_i, .register_format_select_i,
    .rx_valid_i, .rx_data_i, .rx_last_i, .rx_ready_o, .tx_valid_o, .tx_data_o,
    .tx_last_o, .tx_ready_i, .digital_out_o, .analog_reg_o,
    .last_response_function_query_o, .last_exception_code_query_o);
  mb_master_model i_master (.clock_i, .rx_ready_i(rx_ready_o), .tx_valid_i(tx_valid_o),
    .tx_data_i(tx_data_o), .tx_last_i(tx_last_o), .rx_valid_o(rx_valid_i),
    .rx_data_o(rx_data_i), .rx_last_o(rx_last_i), .tx_ready_o(tx_ready_i));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xact(input logic [7:0] req[$], input logic [7:0] exp[$]);
    i_master.transact(req);
    chk(16'(i_master.resp.size()), 16'(exp.size()));
    foreach (exp[i]) chk({8'h00, i_master.resp[i]}, {8'h00, exp[i]});
  endtask
  task automatic wr(input logic [7:0] fc, input logic [15:0] ad, input logic [15:0] qt,
                    input logic [7:0] d[$], input logic [7:0] exc);
    logic [7:0] q[$];
    q = {fc, ad[15:8], ad[7:0], qt[15:8], qt[7:0], 8'(d.size())};
    q = {q, d};
    if (exc == 8'h00) xact(q, {fc, ad[15:8], ad[7:0], qt[15:8], qt[7:0]});
    else xact(q, {fc | 8'h80, exc});
  endtask
  task automatic t_coils();
    wr(8'h0F, 16'h0000, 16'h0010, {8'hAA, 8'h55}, 8'h00);
    chk(digital_out_o, 16'h55AA);
    xact({8'h07}, {8'h07, 8'hAA});
    chk({8'h00, last_response_function_query_o}, 16'h0007);
  endtask
  task automatic t_coil_edge();
    i_master.slow = 1'b1;
    wr(8'h0F, 16'h0004, 16'h0008, {8'h0F}, 8'h00);
    chk(digital_out_o, 16'h50FA);
    wr(8'h0F, 16'h000F, 16'h0002, {8'hFF}, 8'h02);
    wr(8'h0F, 16'h0000, 16'h0011, {8'hFF, 8'hFF, 8'h01}, 8'h02);
    chk(digital_out_o, 16'h50FA);
    chk({8'h00, last_exception_code_query_o}, 16'h0002);
    xact({8'h07}, {8'h07, 8'hFA});
    i_master.slow = 1'b0;
  endtask
  task automatic t_regs();
    wr(8'h10, 16'h0002, 16'h0004, {8'h40, 8'hA0, 8'h00, 8'h00, 8'h40, 8'h40, 8'h00, 8'h00},
       8'h00);
    chk(analog_reg_o[2*16 +: 16], 16'h40A0);
    chk(analog_reg_o[4*16 +: 16], 16'h4040);
    wr(8'h10, 16'h0000, 16'h0002, {8'h11, 8'h22, 8'h33, 8'h44}, 8'h02);
    register_format_select_i = 1'b1;
    wr(8'h10, 16'h0007, 16'h0001, {8'h12, 8'h34}, 8'h00);
    chk(analog_reg_o[7*16 +: 16], 16'h1234);
    wr(8'h10, 16'h0007, 16'h0002, {8'h11, 8'h22, 8'h33, 8'h44}, 8'h02);
    chk(analog_reg_o[7*16 +: 16], 16'h1234);
  endtask
  task automatic t_bad_code();
    xact({8'h03}, {8'h83, 8'h01});
    xact({8'h03, 8'h00, 8'h01}, {8'h83, 8'h01});
    chk({8'h00, last_exception_code_query_o}, 16'h0001);
    chk({8'h00, last_response_function_query_o}, 16'h0083);
  endtask
  task automatic results();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clock_i);
    #1 reset_n_i = 1'b1;
    t_coils();
    t_coil_edge();
    t_regs();
    t_bad_code();
    results();
  end
  initial begin
    #100000;
    n_errors++;
    results();
  end
endmodule
